// >>> rtl/cmd_source_select.sv
// network command source selector with apb register access
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "cmd_source_params.svh"
module cmd_source_select
  import cmd_source_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  term_pins_i,
  input  wire logic        net_start_fwd_i,
  input  wire logic        net_start_rev_i,
  input  wire logic        net_speed_valid_i,
  input  wire logic        net_sel_high_i,
  input  wire logic        net_sel_mid_i,
  input  wire logic        net_sel_low_i,
  input  wire logic        net_pid_valid_i,
  input  wire logic        net_brake_done_i,
  input  wire logic        net_term4_sel_i,
  input  wire logic        net_reset_req_i,
  input  wire logic        running_i,
  output logic             start_fwd_o,
  output logic             start_rev_o,
  output logic             speed_from_net_o,
  output logic             high_speed_o,
  output logic             mid_speed_o,
  output logic             low_speed_o,
  output logic             pid_valid_o,
  output logic             brake_open_done_o,
  output logic             term4_select_o,
  output logic             run_enable_o,
  output logic             thermal_relay_o,
  output logic             pu_interlock_o,
  output logic             drive_reset_o,
  output logic             op_from_net_o,
  output logic [1:0]       comm_path_o
);
  // terminal function codes for each of the seven input terminals
  logic [7:0]  term_func_r [`TERM_COUNT];
  logic [1:0]  op_cmd_source_param_r;
  logic [1:0]  speed_cmd_source_param_r;
  logic [1:0]  write_during_run_param_r;
  logic [1:0]  net_op_path_param_r;
  logic [1:0]  pu_op_path_param_r;
  logic [1:0]  op_src_act_r;
  logic [1:0]  speed_src_act_r;
  logic        switch_act_r;
  logic [6:0]  pins_s;
  logic        running_s;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        switch_assigned;
  logic        cmd_source_switch_in;
  logic        ext_op;
  logic        ext_speed;
  logic [31:0] rd_nxt;
  logic        hit_fwd;
  logic        hit_rev;
  logic        hit_high;
  logic        hit_mid;
  logic        hit_low;
  logic        hit_pid;
  logic        hit_brake;
  logic        hit_term4;
  logic        hit_run_en;
  logic        hit_thermal;
  logic        hit_pu_lock;
  logic        hit_reset;
  src_sel_t    op_sel;
  src_sel_t    speed_sel;

  // pins come from outside the clock domain
  input_sync #(.W(8)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       ({running_i, term_pins_i}),
    .q_o       ({running_s, pins_s})
  );

  function automatic logic is_ext(input logic [1:0] v);
    is_ext = (v == `SRC_EXT) || (v == `SRC_EXT2);
  endfunction : is_ext

  function automatic logic pin_of(input logic [7:0] code, input logic [6:0] pins,
                                  input logic [7:0] f [`TERM_COUNT]);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `TERM_COUNT; i++)
      if (f[i] == code && pins[i])
        hit = 1'b1;
    pin_of = hit;
  endfunction : pin_of

  always_comb
  begin
    switch_assigned = 1'b0;
    for (int i = 0; i < `TERM_COUNT; i++)
      if (term_func_r[i] == `FUNC_SWITCH)
        switch_assigned = 1'b1;
  end

  assign cmd_source_switch_in = pin_of(`FUNC_SWITCH, pins_s, term_func_r);

  // every terminal function is looked up once and shared by the output stage
  always_comb
  begin
    hit_fwd     = pin_of(`FUNC_FWD, pins_s, term_func_r);
    hit_rev     = pin_of(`FUNC_REV, pins_s, term_func_r);
    hit_high    = pin_of(`FUNC_HIGH, pins_s, term_func_r);
    hit_mid     = pin_of(`FUNC_MID, pins_s, term_func_r);
    hit_low     = pin_of(`FUNC_LOW, pins_s, term_func_r);
    hit_pid     = pin_of(`FUNC_PID, pins_s, term_func_r);
    hit_brake   = pin_of(`FUNC_BRAKE, pins_s, term_func_r);
    hit_term4   = pin_of(`FUNC_TERM4, pins_s, term_func_r);
    hit_run_en  = pin_of(`FUNC_RUN_EN, pins_s, term_func_r);
    hit_thermal = pin_of(`FUNC_THERMAL, pins_s, term_func_r);
    hit_pu_lock = pin_of(`FUNC_PU_LOCK, pins_s, term_func_r);
    hit_reset   = pin_of(`FUNC_RESET, pins_s, term_func_r);
  end

  // apb: zero wait states, unmapped offsets answer with pslverr
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign addr_ok = (paddr == `ADDR_CTRL) || (paddr == `ADDR_SRC) ||
                   (paddr == `ADDR_TERM_FUNC) || (paddr == `ADDR_STATUS) ||
                   (paddr == `ADDR_PATH);

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      op_cmd_source_param_r    <= `SRC_NET;
      speed_cmd_source_param_r <= `SRC_NET;
      write_during_run_param_r <= 2'h0;
      net_op_path_param_r      <= 2'h0;
      pu_op_path_param_r       <= 2'h0;
      for (int i = 0; i < `TERM_COUNT; i++)
        term_func_r[i] <= 8'h00;
    end
    else if (wr_en && addr_ok)
    begin
      if (paddr == `ADDR_CTRL)
        write_during_run_param_r <= pwdata[1:0];
      else if (paddr == `ADDR_SRC)
      begin
        // source params writable while running only in run-write mode
        if (!running_s || write_during_run_param_r == `WDR_RUN_WRITE)
        begin
          op_cmd_source_param_r    <= pwdata[1:0];
          speed_cmd_source_param_r <= pwdata[9:8];
        end
      end
      else if (paddr == `ADDR_TERM_FUNC)
      begin
        for (int i = 0; i < `TERM_COUNT; i++)
          if (pwdata[26:24] == 3'(i))
            term_func_r[i] <= pwdata[7:0];
      end
      else if (paddr == `ADDR_PATH)
      begin
        net_op_path_param_r <= pwdata[1:0];
        pu_op_path_param_r  <= pwdata[9:8];
      end
    end
  end

  // active sources only move while stopped, so a mid-run change waits
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      op_src_act_r    <= `SRC_NET;
      speed_src_act_r <= `SRC_NET;
      switch_act_r    <= 1'b1;
    end
    else if (!running_s)
    begin
      op_src_act_r    <= op_cmd_source_param_r;
      speed_src_act_r <= speed_cmd_source_param_r;
      switch_act_r    <= !switch_assigned || cmd_source_switch_in;
    end
  end

  // switch off forces terminals; otherwise the params decide
  always_comb
  begin
    op_sel    = src_network;
    speed_sel = src_network;
    if (!switch_act_r || is_ext(op_src_act_r))
      op_sel = src_terminal;
    if (!switch_act_r || is_ext(speed_src_act_r))
      speed_sel = src_terminal;
  end
  assign ext_op    = (op_sel == src_terminal);
  assign ext_speed = (speed_sel == src_terminal);

  // operation side: start and brake follow the operation source
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      start_fwd_o       <= 1'b0;
      start_rev_o       <= 1'b0;
      brake_open_done_o <= 1'b0;
      op_from_net_o     <= 1'b0;
    end
    else
    begin
      op_from_net_o     <= !ext_op;
      start_fwd_o       <= ext_op ? hit_fwd : net_start_fwd_i;
      start_rev_o       <= ext_op ? hit_rev : net_start_rev_i;
      brake_open_done_o <= ext_op ? hit_brake : net_brake_done_i;
    end
  end

  // speed side: selections follow the speed source
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      speed_from_net_o <= 1'b0;
      high_speed_o     <= 1'b0;
      mid_speed_o      <= 1'b0;
      low_speed_o      <= 1'b0;
      pid_valid_o      <= 1'b0;
      term4_select_o   <= 1'b0;
    end
    else
    begin
      speed_from_net_o <= !ext_speed && net_speed_valid_i;
      high_speed_o     <= ext_speed ? hit_high : net_sel_high_i;
      mid_speed_o      <= ext_speed ? hit_mid : net_sel_mid_i;
      low_speed_o      <= ext_speed ? hit_low : net_sel_low_i;
      pid_valid_o      <= ext_speed ? hit_pid : net_pid_valid_i;
      // terminal 4: no source at all under network speed, both otherwise
      term4_select_o   <= ext_speed && (hit_term4 || net_term4_sel_i);
    end
  end

  // fixed inputs never look at the sources; only drive reset checks the switch
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      run_enable_o    <= 1'b0;
      thermal_relay_o <= 1'b0;
      pu_interlock_o  <= 1'b0;
      drive_reset_o   <= 1'b0;
    end
    else
    begin
      run_enable_o    <= hit_run_en;
      thermal_relay_o <= hit_thermal;
      pu_interlock_o  <= hit_pu_lock;
      // comm reset only honoured while the switch is not holding terminals
      drive_reset_o   <= hit_reset || (switch_act_r && net_reset_req_i);
    end
  end

  // communication path choice passes straight through
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      comm_path_o <= 2'h0;
    else
      comm_path_o <= net_op_path_param_r;
  end

  always_comb
  begin
    rd_nxt = `RESET_SRC;
    if (paddr == `ADDR_CTRL)
      rd_nxt = {30'h0, write_during_run_param_r};
    else if (paddr == `ADDR_SRC)
      rd_nxt = {22'h0, speed_cmd_source_param_r, 6'h0, op_cmd_source_param_r};
    else if (paddr == `ADDR_STATUS)
      rd_nxt = {20'h0, switch_assigned, running_s, speed_src_act_r, 2'h0,
                op_src_act_r, 3'h0, switch_act_r};
    else if (paddr == `ADDR_PATH)
      rd_nxt = {22'h0, pu_op_path_param_r, 6'h0, net_op_path_param_r};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en && !penable)
        prdata <= rd_nxt;
    end
  end
endmodule : cmd_source_select

// >>> rtl/cmd_source_params.svh
// constants for the network command source selector
`ifndef CMD_SOURCE_PARAMS_SVH
`define CMD_SOURCE_PARAMS_SVH
`define ADDR_CTRL        12'h000
`define ADDR_SRC         12'h004
`define ADDR_TERM_FUNC   12'h008
`define ADDR_STATUS      12'h00c
`define ADDR_PATH        12'h010
`define SRC_NET          2'h0
`define SRC_EXT          2'h1
`define SRC_EXT2         2'h2
`define FUNC_SWITCH      8'h43
`define FUNC_LOW         8'h00
`define FUNC_MID         8'h01
`define FUNC_HIGH        8'h02
`define FUNC_TERM4       8'h04
`define FUNC_THERMAL     8'h07
`define FUNC_RUN_EN      8'h0a
`define FUNC_PU_LOCK     8'h0c
`define FUNC_PID         8'h0e
`define FUNC_BRAKE       8'h0f
`define FUNC_FWD         8'h3c
`define FUNC_REV         8'h3d
`define FUNC_RESET       8'h3e
`define TERM_COUNT       7
`define WDR_RUN_WRITE    2'h2
`define RESET_SRC        32'h0000_0000
`endif

// >>> rtl/cmd_source_pkg.sv
// types for the network command source selector
package cmd_source_pkg;
  typedef enum logic [1:0] {
    src_network,
    src_terminal
  } src_sel_t;
endpackage : cmd_source_pkg

// >>> rtl/input_sync.sv
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module input_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : input_sync

// >>> testbench/cmd_source_sva.sv
// assertions for the command source selector
`timescale 1ns/10ps
module cmd_source_sva (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic running_i,
  input wire logic net_start_fwd_i,
  input wire logic net_speed_valid_i,
  input wire logic net_sel_high_i,
  input wire logic net_brake_done_i,
  input wire logic start_fwd_o,
  input wire logic high_speed_o,
  input wire logic brake_open_done_o,
  input wire logic term4_select_o,
  input wire logic op_from_net_o,
  input wire logic speed_from_net_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // two cycles in a row so the check never straddles a source switch
  sequence op_net2;
    op_from_net_o && $past(op_from_net_o);
  endsequence
  sequence sp_net2;
    speed_from_net_o && $past(speed_from_net_o);
  endsequence
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_start_from_net: assert property (op_net2 |->
    start_fwd_o == $past(net_start_fwd_i))
    else $error("start not taken from network");
  a_brake_from_net: assert property (op_net2 |->
    brake_open_done_o == $past(net_brake_done_i))
    else $error("brake done not taken from network");
  a_speed_from_net: assert property (sp_net2 |->
    high_speed_o == $past(net_sel_high_i))
    else $error("speed select not taken from network");
  a_term4_off_net: assert property (sp_net2 |-> !term4_select_o)
    else $error("terminal 4 select active with network speed");
  // sync delay plus latch needs five running cycles before sources freeze; run6 waits for six
  sequence run6;
    running_i [*6];
  endsequence
  // speed flag is qualified by the net valid level, so hold that steady too
  sequence valid2;
    net_speed_valid_i && $past(net_speed_valid_i);
  endsequence
  a_src_hold_run: assert property (run6 |-> $stable(op_from_net_o))
    else $error("operation source changed while running");
  a_speed_hold_run: assert property (run6 ##0 valid2 |=> $stable(speed_from_net_o))
    else $error("speed source changed while running");
endmodule : cmd_source_sva
bind cmd_source_select cmd_source_sva u_sva (
  .sys_clk_i         (sys_clk_i),
  .rst_b_i           (rst_b_i),
  .psel              (psel),
  .penable           (penable),
  .pready            (pready),
  .pslverr           (pslverr),
  .running_i         (running_i),
  .net_start_fwd_i   (net_start_fwd_i),
  .net_speed_valid_i (net_speed_valid_i),
  .net_sel_high_i    (net_sel_high_i),
  .net_brake_done_i  (net_brake_done_i),
  .start_fwd_o       (start_fwd_o),
  .high_speed_o      (high_speed_o),
  .brake_open_done_o (brake_open_done_o),
  .term4_select_o    (term4_select_o),
  .op_from_net_o     (op_from_net_o),
  .speed_from_net_o  (speed_from_net_o)
);

// >>> testbench/comm_master_model.sv
// communication master model driving command levels
`timescale 1ns/10ps
module comm_master_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       send_i,
  input  wire logic [9:0] cmd_i,
  output logic      [9:0] net_cmd_o
);
  // levels move only when a new command frame is sent
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      net_cmd_o <= 10'h0;
    else if (send_i)
      net_cmd_o <= cmd_i;
  end
endmodule : comm_master_model

// >>> testbench/network_command_source_select_bench.sv
// self-checking bench for the command source selector
`timescale 1ns/10ps
`include "cmd_source_params.svh"
module network_command_source_select_bench;
  logic        sys_clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, running_i;
  logic        send, err, sw, t;
  logic [1:0]  op, sp, comm_path_o;
  logic [6:0]  term_pins_i;
  logic [9:0]  cmd, comm_source;
  logic [11:0] paddr;
  wire logic [13:0] outs;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;

  comm_master_model u_comm (.sys_clk_i, .rst_b_i, .send_i(send), .cmd_i(cmd), .net_cmd_o(comm_source));
  cmd_source_select u_dut (.sys_clk_i, .rst_b_i, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .term_pins_i, .running_i, .comm_path_o,
    .net_start_fwd_i(comm_source[0]), .net_start_rev_i(comm_source[1]),
    .net_speed_valid_i(comm_source[2]), .net_sel_high_i(comm_source[3]), .net_sel_mid_i(comm_source[4]),
    .net_sel_low_i(comm_source[5]), .net_pid_valid_i(comm_source[6]), .net_brake_done_i(comm_source[7]),
    .net_term4_sel_i(comm_source[8]), .net_reset_req_i(comm_source[9]), .start_fwd_o(outs[0]),
    .start_rev_o(outs[1]), .speed_from_net_o(outs[2]), .high_speed_o(outs[3]),
    .mid_speed_o(outs[4]), .low_speed_o(outs[5]), .pid_valid_o(outs[6]),
    .brake_open_done_o(outs[7]), .term4_select_o(outs[8]), .run_enable_o(outs[9]),
    .thermal_relay_o(outs[10]), .pu_interlock_o(outs[11]), .drive_reset_o(outs[12]),
    .op_from_net_o(outs[13]));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic results;
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      results();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // unassigned terminals keep code 00 (low speed) but their pins stay low, so only net paths and run enable show
  function automatic logic [13:0] exp_outs(input logic on, o, s, r, input logic [9:0] c);
    logic [13:0] e;
    e = '0;
    e[1:0] = {2{o}} & c[1:0];
    e[2] = s & c[2];
    e[6:3] = {4{s}} & c[6:3];
    e[7] = o & c[7];
    e[8] = !s & c[8];
    e[9] = r;
    e[12] = on & c[9];
    e[13] = o;
    return e;
  endfunction : exp_outs

  initial
  begin
    {rst_b_i, psel, penable, pwrite, running_i, send, paddr, pwdata, term_pins_i, cmd} = '0;
    void'($urandom(32'h8ee3));
    repeat (6) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    send <= 1'b1;
    apb(1'b0, `ADDR_STATUS, '0);
    cmp(rd, 32'h1);
    apb(1'b0, 12'h014, '0);
    cmp(err, 1'b1);
    apb(1'b1, `ADDR_TERM_FUNC, {5'h0, 3'h3, 16'h0, `FUNC_SWITCH});
    apb(1'b1, `ADDR_TERM_FUNC, 32'h0a);
    apb(1'b1, `ADDR_CTRL, {30'h0, `WDR_RUN_WRITE});
    for (int i = 0; i < 14; i++)
    begin
      op = 2'($urandom_range(1, 0));
      sp = 2'($urandom_range(2, 0));
      sw = 1'($urandom_range(1, 0));
      t = 1'($urandom_range(1, 0));
      cmd <= 10'($urandom);
      term_pins_i <= {3'h0, sw, 2'h0, t};
      apb(1'b1, `ADDR_SRC, {22'h0, sp, 6'h0, op});
      apb(1'b1, `ADDR_PATH, {22'h0, ~op, 6'h0, sp});
      repeat (5) @(posedge sys_clk_i);
      cmp(outs, exp_outs(sw, sw && op == 2'h0, sw && sp == 2'h0, t, cmd));
      cmp(comm_path_o, sp);
    end
    term_pins_i <= 7'h08;
    cmd <= 10'h004;
    apb(1'b1, `ADDR_SRC, 32'h0);
    running_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    apb(1'b1, `ADDR_SRC, 32'h101);
    term_pins_i <= 7'h00;
    repeat (6) @(posedge sys_clk_i);
    cmp(outs[13], 1'b1);
    cmp(outs[2], 1'b1);
    running_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    cmp(outs[13], 1'b0);
    term_pins_i <= 7'h08;
    repeat (6) @(posedge sys_clk_i);
    cmp(outs[2], 1'b0);
    results();
  end
endmodule : network_command_source_select_bench
